// *** core/hrx_apb_ctrl.sv ***
// APB slave holding the hires_control register
`timescale 1ns/1ns
module hrx_apb_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [1:0] resolution_enable_select,
  output logic eightfold_mode_enable
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] en;    // Which timer/counters are extended
    logic plus;        // Eightfold instead of fourfold
  } hrx_ctrl_state_type;

  hrx_ctrl_state_type state_q;  // Registered copy
  hrx_ctrl_state_type state_d;  // Next value
  logic hit;                    // Address decodes to hires_control
  logic wr_en;                  // Access phase of a write to hires_control

  assign hit = paddr[11:2] == hrx_pkg::HRX_CTRL_ADDR[11:2];
  assign wr_en = psel && penable && pwrite && hit;

  // Zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  // Unmapped words answer with an error rather than silently aliasing
  assign pslverr = psel && penable && !hit;

  // Upper bits read as zero; reserved write bits are dropped here
  always_comb begin
    prdata = 32'h0000_0000;
    if (psel && !pwrite && hit) begin
      prdata[hrx_pkg::HRX_EN_LSB +: 2] = state_q.en;
      prdata[hrx_pkg::HRX_PLUS_BIT] = state_q.plus;
    end
  end

  // Next-state: store enable field and plus bit on a write
  always_comb begin
    state_d = state_q;
    if (wr_en) begin
      state_d.en = pwdata[hrx_pkg::HRX_EN_LSB +: 2];
      state_d.plus = pwdata[hrx_pkg::HRX_PLUS_BIT];
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= hrx_ctrl_state_type'(hrx_pkg::HRX_CTRL_RESET[2:0]);
    end else begin
      state_q <= state_d;
    end
  end

  assign resolution_enable_select = state_q.en;
  assign eightfold_mode_enable = state_q.plus;

endmodule

// *** core/hrx_fine_chan.sv ***
// Sub-cycle edge placement for one compare channel
`timescale 1ns/1ns
module hrx_fine_chan (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic hires_en,
  input wire logic plus_mode,
  input wire logic count_down,
  input wire hrx_pkg::hrx_wg_mode_type wave_mode,
  input wire logic [15:0] tc_count,
  input wire logic [15:0] tc_compare,
  input wire logic tc_wave,
  output logic [7:0] wave_pattern
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wave;            // Level shown in the previous cycle
    logic [7:0] pattern;   // Sub-slot levels, slot 0 first in time
  } hrx_chan_state_type;

  hrx_chan_state_type state_q;  // Registered copy
  hrx_chan_state_type state_d;  // Next value
  logic [15:0] mask;            // Bits compared by the timer/counter
  logic [2:0] fine;             // Edge position in eighths of a cycle
  logic match;                  // Coarse compare hit this cycle
  logic [3:0] pos;              // First slot carrying the new level

  // Place the changed level at the slot the hidden compare bits name
  always_comb begin
    state_d = state_q;
    mask = plus_mode ? hrx_pkg::HRX_MASK_OCT : hrx_pkg::HRX_MASK_QUAD;
    // Fourfold slots are pairs of eighths
    fine = plus_mode ? tc_compare[2:0] : {tc_compare[1:0], 1'b0};
    match = (tc_count & mask) == (tc_compare & mask);
    pos = 4'h0;
    // Edges not caused by compare (bottom, top) land on slot zero
    if (hires_en && (tc_wave != state_q.wave) && match) begin
      if (count_down && wave_mode == hrx_pkg::hrx_wg_dual_slope && fine != 3'h0) begin
        pos = hrx_pkg::HRX_SLOT_END - {1'b0, fine};
      end else begin
        pos = {1'b0, fine};
      end
    end
    for (int i = 0; i < hrx_pkg::HRX_SLOTS; i++) begin
      state_d.pattern[i] = (4'(i) >= pos) ? tc_wave : state_q.wave;
    end
    if (!hires_en) begin
      state_d.pattern = {8{tc_wave}};
    end else if (wave_mode != hrx_pkg::hrx_wg_frequency_waveform &&
                 tc_compare < hrx_pkg::HRX_MIN_COMPARE) begin
      // Sub-cycle pulses cannot pass the pad; suppress them entirely
      state_d.pattern = 8'h00;
    end
    state_d.wave = tc_wave;
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign wave_pattern = state_q.pattern;

endmodule

// *** core/hrx_top.sv ***
// High-resolution waveform extension for the two timer/counters of one port
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ns
// Contract
// - Counter compares upper bits; extension compares low
// - Counter skips low bits, steps by four
// - Count reads return zero low bits
// - Events ignore the low count bits
// - Plus mode takes three bits, eightfold
// - Bit two selects eightfold mode
// - Enable field selects which counters extend
// - Any enable extends the whole port
// - Compare below four gives no pulse; the code still passes such pulses in frequency waveform mode
// - Frequency, single, dual slope, dead-time supported
module hrx_top #(
  parameter int NUM_CC = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0][15:0] tc_count,
  input wire logic [1:0] tc_count_down,
  input wire hrx_pkg::hrx_wg_mode_type [1:0] tc_wave_mode,
  input wire logic [1:0][NUM_CC-1:0][15:0] tc_compare,
  input wire logic [1:0][NUM_CC-1:0] tc_wave,
  output logic [1:0][15:0] count_view,
  output logic [1:0][1:0] count_step_log2,
  output logic hires_port_active,
  output logic [1:0][NUM_CC-1:0][7:0] wave_pattern
);

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  logic [1:0] resolution_enable_select;  // Per-counter extension enable
  logic eightfold_mode_enable;           // Plus mode

  hrx_apb_ctrl u_ctrl (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .resolution_enable_select(resolution_enable_select),
    .eightfold_mode_enable(eightfold_mode_enable)
  );

  // ----------------------------------------------------------------
  // Counter-facing state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0][15:0] cnt;   // Count seen by software and event logic
    logic [1:0][1:0] step;   // Count increment exponent for each counter
    logic port;              // Port pads sample the sub-slot patterns
  } hrx_top_state_type;

  hrx_top_state_type state_q;  // Registered copy
  hrx_top_state_type state_d;  // Next value

  // Hide the low bits owned by the extension and tell the counter
  // how far to step; a disabled counter sees its own full count
  always_comb begin
    state_d = state_q;
    for (int t = 0; t < hrx_pkg::HRX_NUM_TC; t++) begin
      if (!resolution_enable_select[t]) begin
        state_d.cnt[t] = tc_count[t];
        state_d.step[t] = hrx_pkg::HRX_STEP_NONE;
      end else if (eightfold_mode_enable) begin
        // One mask serves the read path and the event path alike
        state_d.cnt[t] = tc_count[t] & hrx_pkg::HRX_MASK_OCT;
        state_d.step[t] = hrx_pkg::HRX_STEP_OCT;
      end else begin
        state_d.cnt[t] = tc_count[t] & hrx_pkg::HRX_MASK_QUAD;
        state_d.step[t] = hrx_pkg::HRX_STEP_QUAD;
      end
    end
    // Port-wide: one counter enabled switches every pin of the port
    state_d.port = |resolution_enable_select;
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign count_view = state_q.cnt;
  assign count_step_log2 = state_q.step;
  assign hires_port_active = state_q.port;

  // ----------------------------------------------------------------
  // Fine edge placement, one per compare channel
  // ----------------------------------------------------------------
  // Patterns follow the counter waveform by one cycle; the dead-time
  // unit downstream sees the same delay on every channel, so its
  // timing between complementary outputs is preserved.
  for (genvar g = 0; g < hrx_pkg::HRX_NUM_TC * NUM_CC; g++) begin : g_chan
    localparam int T = g / NUM_CC;  // Timer/counter index
    localparam int C = g % NUM_CC;  // Channel index
    hrx_fine_chan u_chan (
      .pclk(pclk),
      .presetn(presetn),
      .hires_en(resolution_enable_select[T]),
      .plus_mode(eightfold_mode_enable),
      .count_down(tc_count_down[T]),
      .wave_mode(tc_wave_mode[T]),
      .tc_count(tc_count[T]),
      .tc_compare(tc_compare[T][C]),
      .tc_wave(tc_wave[T][C]),
      .wave_pattern(wave_pattern[T][C])
    );
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_count_low_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    (resolution_enable_select[0] && !eightfold_mode_enable)
      |=> (count_view[0][1:0] == 2'h0 && count_view[0][15:2] == $past(tc_count[0][15:2])))
    else $error("count low bits not hidden");

  a_plus_three_bits: assert property (
    @(posedge pclk) disable iff (!presetn)
    (resolution_enable_select[1] && eightfold_mode_enable)
      |=> (count_view[1][2:0] == 3'h0 && count_step_log2[1] == 2'h3))
    else $error("plus mode does not hide three bits");

  a_step_by_four: assert property (
    @(posedge pclk) disable iff (!presetn)
    (resolution_enable_select[0] && !eightfold_mode_enable) |=> count_step_log2[0] == 2'h2)
    else $error("counter not stepping by four");

  a_disabled_passes: assert property (
    @(posedge pclk) disable iff (!presetn)
    !resolution_enable_select[0]
      |=> (count_view[0] == $past(tc_count[0]) && count_step_log2[0] == 2'h0
           && wave_pattern[0][0] == {8{$past(tc_wave[0][0])}}))
    else $error("disabled counter altered");

  a_port_wide: assert property (
    @(posedge pclk) disable iff (!presetn)
    ##1 hires_port_active == $past(|resolution_enable_select))
    else $error("port activity wrong");

  a_short_pulse: assert property (
    @(posedge pclk) disable iff (!presetn)
    (resolution_enable_select[0] && tc_compare[0][1] < 16'h0004
     && tc_wave_mode[0] != hrx_pkg::hrx_wg_frequency_waveform)
      |=> wave_pattern[0][1] == 8'h00)
    else $error("sub-cycle pulse emitted");

  a_enable_select: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && pwrite && paddr == 12'h000 && pwdata[1:0] == 2'b10)
      |=> ##1 (count_step_log2[0] == 2'h0 && count_step_log2[1] != 2'h0))
    else $error("enable field selects wrong counter");

  a_plus_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && pwrite && paddr == 12'h000 && pwdata[2:0] == 3'b111)
      |=> ##1 (count_step_log2 == {2'h3, 2'h3}))
    else $error("plus bit does not select eightfold");

  a_fine_edge: assert property (
    @(posedge pclk) disable iff (!presetn)
    (resolution_enable_select[0] && !eightfold_mode_enable && !tc_count_down[0]
     && tc_compare[0][0] >= 16'h0004
     && tc_count[0][15:2] == tc_compare[0][0][15:2] && tc_compare[0][0][1:0] == 2'h2
     && tc_wave[0][0] && !$past(tc_wave[0][0]) && $past(presetn))
      |=> wave_pattern[0][0] == 8'hf0)
    else $error("fine edge misplaced");

endmodule

// *** shared/hrx_pkg.sv ***
// Constants and types shared by the high-resolution waveform extension
package hrx_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int HRX_ADDR_W = 12;                         // APB address width
  localparam logic [11:0] HRX_CTRL_ADDR = 12'h000;        // hires_control offset
  localparam logic [7:0] HRX_CTRL_RESET = 8'h00;          // hires_control reset
  localparam int HRX_EN_LSB = 0;                          // resolution_enable_select[1:0]
  localparam int HRX_PLUS_BIT = 2;                        // eightfold_mode_enable

  // ----------------------------------------------------------------
  // Resolution geometry
  // ----------------------------------------------------------------
  localparam int HRX_NUM_TC = 2;                          // Timer/counters on one port
  localparam int HRX_SLOTS = 8;                           // Sub-slots per peripheral cycle
  localparam logic [1:0] HRX_STEP_NONE = 2'h0;            // Count by one
  localparam logic [1:0] HRX_STEP_QUAD = 2'h2;            // Count by four
  localparam logic [1:0] HRX_STEP_OCT = 2'h3;             // Count by eight
  localparam logic [15:0] HRX_MASK_NONE = 16'hffff;       // Full count visible
  localparam logic [15:0] HRX_MASK_QUAD = 16'hfffc;       // Two low bits hidden
  localparam logic [15:0] HRX_MASK_OCT = 16'hfff8;        // Three low bits hidden
  localparam logic [15:0] HRX_MIN_COMPARE = 16'h0004;     // Shortest visible compare
  localparam logic [3:0] HRX_SLOT_END = 4'h8;             // Mirror base for down-count

  // Waveform generation mode reported by the timer/counter
  typedef enum logic [1:0] {
    hrx_wg_normal,
    hrx_wg_frequency_waveform,
    hrx_wg_single_slope,
    hrx_wg_dual_slope
  } hrx_wg_mode_type;

endpackage

// *** test/hires_waveform_extension_bench.sv ***
// Self-checking bench for the high-resolution waveform extension
`timescale 1ns/1ns
module hires_waveform_extension_bench;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0; // Held low for five cycles
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0][15:0] tc_count;
  logic [1:0][15:0] count_view;
  logic [1:0] tc_count_down;
  hrx_pkg::hrx_wg_mode_type [1:0] tc_wave_mode = '0;
  // Fine parts cover low values 1, 2, 3, 5, 6 and 7 (not 0 or 4), two of them below four
  logic [1:0][3:0][15:0] tc_compare = {16'h0036, 16'h0019, 16'h0003, 16'h0027,
                                       16'h0033, 16'h0025, 16'h0002, 16'h0012};
  logic [1:0][3:0] tc_wave;
  logic [1:0][1:0] count_step_log2;
  logic hires_port_active;
  logic [1:0][3:0][7:0] wave_pattern;
  int fails = 0;
  int n_compared = 0;
  logic [2:0] ctl = 3'h0; // Shadow of the control register
  // Snapshot of what the design sampled at the last edge
  logic [2:0] s_ctl;
  logic [1:0][15:0] s_cnt;
  logic [1:0] s_dn;
  hrx_pkg::hrx_wg_mode_type [1:0] s_mode;
  logic [1:0][3:0] s_wave;
  logic [1:0][3:0] s_old;
  int s_n = 0;

  // 10 MHz; the eight pattern slots stand in for the quad-rate clock
  always #50 pclk = ~pclk;

  hrx_top #(.NUM_CC(4)) u_hrx_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tc_count(tc_count), .tc_count_down(tc_count_down),
    .tc_wave_mode(tc_wave_mode), .tc_compare(tc_compare), .tc_wave(tc_wave),
    .count_view(count_view), .count_step_log2(count_step_log2),
    .hires_port_active(hires_port_active), .wave_pattern(wave_pattern));

  hrx_tc_model #(.NUM_CC(4)) u_hrx_tc_model (.pclk(pclk), .presetn(presetn),
    .step_log2(count_step_log2), .wave_mode(tc_wave_mode), .compare(tc_compare),
    .count(tc_count), .count_down(tc_count_down), .wave(tc_wave));

  // ----------------------------------------------------------------
  // Compare and bus tasks
  // ----------------------------------------------------------------
  task automatic chk_reg(input string what, input logic [31:0] exp, input logic [31:0] seen);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic chk_out(input string what, input logic [15:0] exp, input logic [15:0] seen);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One transfer; request held until pready is seen at an edge
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) fails++;
    rd = prdata;
    err = pslverr;
    if (w && a == hrx_pkg::HRX_CTRL_ADDR && err === 1'b0) ctl = wd[2:0];
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e_err);
    logic [31:0] rd;
    logic err;
    apb(a, 1'b1, d, rd, err);
    chk_reg("pslverr", {31'h0, e_err}, {31'h0, err});
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic e_err);
    logic [31:0] v;
    logic err;
    apb(a, 1'b0, 32'h0, v, err);
    chk_reg("prdata", exp, v);
    chk_reg("pslverr", {31'h0, e_err}, {31'h0, err});
  endtask

  // Expected eight-slot pattern of one channel
  function automatic logic [7:0] exp_pat(input logic en, input logic plus, input logic dn,
      input logic old, input logic nw, input hrx_pkg::hrx_wg_mode_type md,
      input logic [15:0] cnt, input logic [15:0] cmp);
    logic [15:0] m;
    logic [3:0] p;
    logic [7:0] r;
    m = plus ? hrx_pkg::HRX_MASK_OCT : hrx_pkg::HRX_MASK_QUAD;
    p = plus ? {1'b0, cmp[2:0]} : {1'b0, cmp[1:0], 1'b0};
    // A mirrored edge applies only on the way down in dual slope
    if (dn && md == hrx_pkg::hrx_wg_dual_slope && p != 4'h0) p = hrx_pkg::HRX_SLOT_END - p;
    for (int i = 0; i < 8; i++) r[i] = (i < p) ? old : nw;
    if (!en) begin
      r = {8{nw}};
    end else if (cmp < hrx_pkg::HRX_MIN_COMPARE && md != hrx_pkg::hrx_wg_frequency_waveform) begin
      r = 8'h00;
    end else if (old == nw || (cnt & m) != (cmp & m)) begin
      r = {8{nw}};
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Cycle scoreboard: outputs follow the inputs of the previous edge
  // ----------------------------------------------------------------
  always @(posedge pclk) begin
    #1;
    if (!presetn) begin
      s_n = 0;
    end else begin
      if (s_n >= 2) begin
        chk_out("port_active", {15'h0, |s_ctl[1:0]}, {15'h0, hires_port_active});
        for (int t = 0; t < 2; t++) begin
          chk_out("count_view", s_ctl[t] ? s_cnt[t] & (s_ctl[2] ? hrx_pkg::HRX_MASK_OCT
            : hrx_pkg::HRX_MASK_QUAD) : s_cnt[t], count_view[t]);
          chk_out("step", {14'h0, s_ctl[t] ? (s_ctl[2] ? hrx_pkg::HRX_STEP_OCT
            : hrx_pkg::HRX_STEP_QUAD) : hrx_pkg::HRX_STEP_NONE},
            {14'h0, count_step_log2[t]});
          for (int c = 0; c < 4; c++) begin
            chk_out("wave_pattern", {8'h00, exp_pat(s_ctl[t], s_ctl[2], s_dn[t], s_old[t][c],
              s_wave[t][c], s_mode[t], s_cnt[t], tc_compare[t][c])},
              {8'h00, wave_pattern[t][c]});
          end
        end
      end
      s_old = s_wave;
      s_ctl = ctl;
      s_cnt = tc_count;
      s_dn = tc_count_down;
      s_mode = tc_wave_mode;
      s_wave = tc_wave;
      s_n++;
    end
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(hrx_pkg::HRX_CTRL_ADDR, {24'h0, hrx_pkg::HRX_CTRL_RESET}, 1'b0);
    wr(12'h004, 32'h0000_0007, 1'b1); // Unmapped word is refused
    rd(12'h004, 32'h0, 1'b1);
    rd(hrx_pkg::HRX_CTRL_ADDR, 32'h0, 1'b0);
    $display("Test register access done");
    // Every mode, paired with the next mode on the second counter, every enable code, both resolutions
    for (int m = 0; m < 4; m++) begin
      for (int v = 0; v < 8; v++) begin
        tc_wave_mode[0] <= hrx_pkg::hrx_wg_mode_type'(m);
        tc_wave_mode[1] <= hrx_pkg::hrx_wg_mode_type'((m + 1) % 4);
        wr(hrx_pkg::HRX_CTRL_ADDR, {29'h0, v[2:0]}, 1'b0);
        rd(hrx_pkg::HRX_CTRL_ADDR, {29'h0, v[2:0]}, 1'b0);
        repeat (40) @(posedge pclk);
        $display("Test mode %0d control %0d done", m, v);
      end
    end
    wrap_up();
  end

  // Cuts a hang short well beyond the expected run length
  initial begin
    repeat (6000) @(posedge pclk);
    fails++;
    wrap_up();
  end

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
endmodule

// *** test/hrx_tc_model.sv ***
// Model of the two timer/counters of one port facing the extension
`timescale 1ns/1ns
module hrx_tc_model #(
  parameter int NUM_CC = 4,
  parameter logic [15:0] PERIOD = 16'h0040 // Low three bits kept clear
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0][1:0] step_log2, // Step asked for by the extension
  input wire hrx_pkg::hrx_wg_mode_type [1:0] wave_mode,
  input wire logic [1:0][NUM_CC-1:0][15:0] compare,
  output logic [1:0][15:0] count,
  output logic [1:0] count_down,
  output logic [1:0][NUM_CC-1:0] wave
);
  // ----------------------------------------------------------------
  // Counting
  // ----------------------------------------------------------------
  // Low bits hidden by the step are kept through steps and wraps, so a masked count view is really tested
  always_ff @(posedge pclk or negedge presetn) begin
    logic [15:0] inc;
    logic [15:0] m;
    logic nd;
    if (!presetn) begin
      count <= '0;
      count_down <= '0;
    end else begin
      for (int t = 0; t < 2; t++) begin
        inc = 16'h0001 << step_log2[t];
        m = ~(inc - 16'h0001);
        nd = count_down[t];
        // Only dual slope turns round; other modes wrap to bottom
        if (wave_mode[t] != hrx_pkg::hrx_wg_dual_slope) begin
          nd = 1'b0;
        end else if ((count[t] & m) >= PERIOD) begin
          nd = 1'b1;
        end else if ((count[t] & m) == 16'h0000) begin
          nd = 1'b0;
        end
        count_down[t] <= nd;
        if (!nd && (count[t] & m) >= PERIOD) begin
          count[t] <= count[t] & ~m;
        end else begin
          count[t] <= nd ? count[t] - inc : count[t] + inc;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Coarse waveform: edges fall on a match of the upper bits only
  // ----------------------------------------------------------------
  always_comb begin
    logic [15:0] m;
    m = 16'h0000;
    for (int t = 0; t < 2; t++) begin
      m = ~((16'h0001 << step_log2[t]) - 16'h0001);
      for (int c = 0; c < NUM_CC; c++) begin
        wave[t][c] = count_down[t] ? (count[t] & m) > (compare[t][c] & m)
                                   : (count[t] & m) >= (compare[t][c] & m);
      end
    end
  end
endmodule
